// >>> hw/fsu_consts.svh
`ifndef FSU_CONSTS_SVH
`define FSU_CONSTS_SVH

// widths
`define FSU_DATA_W 8
`define FSU_CNT_W 4
`define FSU_EVT_N 3

// field positions
`define FSU_MSB 7
`define FSU_WM_TWO_BIT 1
`define FSU_EVT_RISE 0
`define FSU_EVT_FALL 1
`define FSU_EVT_START 2

// wire mode codes
`define FSU_WM_HOLD_OVF 2'h3

// counter values
`define FSU_CNT_TOP 4'hF
`define FSU_CNT_ONE 4'h1
`define FSU_CNT_ACK 4'hE

// reset values
`define FSU_DATA_RST 8'h00
`define FSU_CNT_RST 4'h0
`define FSU_SCL_RST 1'b0
`define FSU_LATCH_RST 1'b0

// timing, bench system clock period in ns
`define FSU_SYS_PERIOD_NS 10

`endif

// >>> hw/fsu_evt_sync.sv
`timescale 1ns/1ns
`include "fsu_consts.svh"

module fsu_evt_sync
#(
  parameter int N = `FSU_EVT_N
)
(
  input wire logic sys_clk,
  input wire logic rst,
  fsu_link_if.sync lk,
  output logic [N-1:0] evt_pulse,
  output logic di_sys
);
  logic di_meta_r;
  logic di_s_r;

  //////////////////////////////////////////////////////////////////////////
  // one toggle synchroniser per event
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_evt
      logic meta_r;
      logic s_r;
      logic p_r;
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          s_r <= 1'b0;
          p_r <= 1'b0;
        end
        else
        begin
          meta_r <= lk.evt_tgl[g];
          s_r <= meta_r;
          p_r <= s_r;
        end
      end
      assign evt_pulse[g] = s_r ^ p_r;
    end
  endgenerate

  // data level shares the toggles' latency, so it is valid at the pulse
  always_ff @(posedge sys_clk)
  begin
    di_meta_r <= lk.di_lvl;
    di_s_r <= di_meta_r;
  end

  assign di_sys = di_s_r;
endmodule

// >>> hw/fsu_link_front.sv
`timescale 1ns/1ns
`include "fsu_consts.svh"

module fsu_link_front
(
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  fsu_link_if.front lk
);
  logic rst_meta_r;
  logic rst_link_r;
  logic scl_meta_r;
  logic scl_s_r;
  logic scl_p_r;
  logic sda_meta_r;
  logic sda_s_r;
  logic sda_p_r;
  logic [`FSU_EVT_N-1:0] evt_tgl_r;
  logic [`FSU_EVT_N-1:0] evt_now;

  //////////////////////////////////////////////////////////////////////////
  // reset and pins cross into the link domain
  always_ff @(posedge link_clk)
  begin
    rst_meta_r <= rst;
    rst_link_r <= rst_meta_r;
  end

  always_ff @(posedge link_clk)
  begin
    scl_meta_r <= scl_i;
    scl_s_r <= scl_meta_r;
    scl_p_r <= scl_s_r;
    sda_meta_r <= sda_i;
    sda_s_r <= sda_meta_r;
    sda_p_r <= sda_s_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // edges and start condition; no glitch filter on the lines
  assign evt_now[`FSU_EVT_RISE] = scl_s_r & ~scl_p_r;
  assign evt_now[`FSU_EVT_FALL] = ~scl_s_r & scl_p_r;
  assign evt_now[`FSU_EVT_START] = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;

  // events leave as toggles so a slow sys side never misses one
  always_ff @(posedge link_clk)
  begin
    if (rst_link_r)
      evt_tgl_r <= '0;
    else
      evt_tgl_r <= evt_tgl_r ^ evt_now;
  end

  assign lk.evt_tgl = evt_tgl_r;
  assign lk.di_lvl = sda_s_r;
endmodule

// >>> hw/fsu_link_if.sv
`timescale 1ns/1ns
`include "fsu_consts.svh"

interface fsu_link_if;
  logic [`FSU_EVT_N-1:0] evt_tgl;
  logic di_lvl;

  modport front
  (
    output evt_tgl,
    output di_lvl
  );

  modport sync
  (
    input evt_tgl,
    input di_lvl
  );
endinterface

// >>> hw/fsu_pkg.sv
package fsu_pkg;

  typedef enum logic [1:0]
  {
    FSU_HOLD_IDLE,
    FSU_HOLD_ARMED,
    FSU_HOLD_LOW
  } fsu_hold_t;

endpackage

// >>> hw/fsu_top.sv
`timescale 1ns/1ns
`include "fsu_consts.svh"

module fsu_top
  import fsu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_in_pin_o,
  output logic serial_data_in_pin_oe,
  output logic data_out_pin_o,
  output logic data_out_pin_oe,
  input wire logic [1:0] wire_mode,
  input wire logic external_clock_select,
  input wire logic external_edge_select,
  input wire logic software_clock_strobe,
  input wire logic clock_toggle_strobe,
  input wire logic port_clock_toggle,
  input wire logic clock_pin_dir,
  input wire logic data_pin_dir,
  input wire logic timer0_compare_match,
  input wire logic data_wr,
  input wire logic [`FSU_DATA_W-1:0] data_wdata,
  input wire logic counter_wr,
  input wire logic [`FSU_CNT_W-1:0] counter_wdata,
  input wire logic overflow_flag_clear,
  input wire logic start_flag_clear,
  output logic [`FSU_DATA_W-1:0] serial_shift_register,
  output logic [`FSU_CNT_W-1:0] counter_value,
  output logic counter_overflow_flag,
  output logic start_condition_flag,
  output logic idle_wake
);
  logic [`FSU_EVT_N-1:0] evt;
  logic di_sys;
  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic two_wire;
  logic ext;
  logic sample_ev;
  logic opp_ev;
  logic cnt_ev;
  logic ovf_set;
  logic start_set;
  logic scl_hold;
  logic [`FSU_DATA_W-1:0] shift_r;
  logic [`FSU_DATA_W-1:0] shift_nxt;
  logic [`FSU_CNT_W-1:0] cnt_r;
  logic ovf_r;
  logic start_r;
  logic latch_r;
  logic latch_open_r;
  logic scl_level_r;
  logic scl_o_r;
  logic scl_oe_r;
  logic sda_o_r;
  logic sda_oe_r;
  logic do_o_r;
  logic do_oe_r;
  logic wake_r;
  fsu_hold_t hold_r;
  fsu_hold_t hold_nxt;

  //////////////////////////////////////////////////////////////////////////
  // link side and crossing
  fsu_link_if u_link_if();

  fsu_link_front u_front
  (
    .link_clk(link_clk),
    .rst(rst),
    .scl_i(serial_clock_pin_i),
    .sda_i(serial_data_in_pin_i),
    .lk(u_link_if.front)
  );

  fsu_evt_sync #(.N(`FSU_EVT_N)) u_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .lk(u_link_if.sync),
    .evt_pulse(evt),
    .di_sys(di_sys)
  );

  assign ev_rise = evt[`FSU_EVT_RISE];
  assign ev_fall = evt[`FSU_EVT_FALL];
  assign ev_start = evt[`FSU_EVT_START];

  //////////////////////////////////////////////////////////////////////////
  // clock source selection
  assign two_wire = wire_mode[`FSU_WM_TWO_BIT];
  assign ext = external_clock_select;

  // sampling edge; in two-wire mode the same pin edges shift
  assign sample_ev = ext ?
    (external_edge_select ? ev_fall : ev_rise) :
    (external_edge_select ? timer0_compare_match :
     software_clock_strobe);

  assign opp_ev = ext &
    (external_edge_select ? ev_rise : ev_fall);

  // counter follows the shift clock; external source counts both edges, or toggle strobes when software_clock_strobe is set
  assign cnt_ev = ext ?
    (software_clock_strobe ? clock_toggle_strobe : (ev_rise | ev_fall)) :
    sample_ev;

  //////////////////////////////////////////////////////////////////////////
  // shift register
  always_comb
  begin
    shift_nxt = shift_r;
    if (data_wr)
      shift_nxt = data_wdata;
    else if (sample_ev)
      shift_nxt = {shift_r[`FSU_MSB-1:0], di_sys};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      shift_r <= `FSU_DATA_RST;
    else
      shift_r <= shift_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // output latch: open after the opposite edge, shut at the sampling edge
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      latch_open_r <= 1'b1;
    else if (ext && sample_ev)
      latch_open_r <= 1'b0;
    else if (opp_ev)
      latch_open_r <= 1'b1;
  end

  // internal clocks keep it open, so a new msb shows at once
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      latch_r <= `FSU_LATCH_RST;
    else if (!ext || (latch_open_r && !sample_ev) || opp_ev)
      latch_r <= shift_nxt[`FSU_MSB];
  end

  //////////////////////////////////////////////////////////////////////////
  // edge counter
  assign ovf_set = cnt_ev && !counter_wr &&
    (cnt_r == `FSU_CNT_TOP);

  // a preload of 14 lets the acknowledge slot end after two edges
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_r <= `FSU_CNT_RST;
    else if (counter_wr)
      cnt_r <= counter_wdata;
    else if (cnt_ev)
      cnt_r <= cnt_r + `FSU_CNT_ONE;
  end

  // set beats clear so an overflow in the clearing cycle survives
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ovf_r <= 1'b0;
    else
      ovf_r <= ovf_set | (ovf_r & ~overflow_flag_clear);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wake_r <= 1'b0;
    else
      wake_r <= ovf_set | (ovf_r & ~overflow_flag_clear);
  end

  //////////////////////////////////////////////////////////////////////////
  // start detector
  assign start_set = two_wire & ev_start;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      start_r <= 1'b0;
    else
      start_r <= start_set | (start_r & ~start_flag_clear);
  end

  always_comb
  begin
    hold_nxt = hold_r;
    case (hold_r)
      FSU_HOLD_IDLE:
        if (start_set)
          hold_nxt = FSU_HOLD_ARMED;
      FSU_HOLD_ARMED:
        if (start_flag_clear)
          hold_nxt = FSU_HOLD_IDLE;
        else if (ev_fall)
          hold_nxt = FSU_HOLD_LOW;
      FSU_HOLD_LOW:
        if (start_flag_clear)
          hold_nxt = FSU_HOLD_IDLE;
      default:
        hold_nxt = FSU_HOLD_IDLE;
    endcase
    if (start_set)
      hold_nxt = FSU_HOLD_ARMED;
    if (!two_wire)
      hold_nxt = FSU_HOLD_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hold_r <= FSU_HOLD_IDLE;
    else
      hold_r <= hold_nxt;
  end

  // only a slave stretches; masters just leave the hold modes off
  assign scl_hold = (hold_r == FSU_HOLD_LOW) ||
    ((wire_mode == `FSU_WM_HOLD_OVF) && ovf_r);

  //////////////////////////////////////////////////////////////////////////
  // clock pin; one strobe per cycle gives half the system rate
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      scl_level_r <= `FSU_SCL_RST;
    else if (clock_toggle_strobe ^ port_clock_toggle)
      scl_level_r <= ~scl_level_r;
  end

  // two-wire lines are open drain: driven only while low
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_o_r <= `FSU_SCL_RST;
      scl_oe_r <= 1'b0;
    end
    else
    begin
      scl_o_r <= scl_level_r & ~scl_hold;
      scl_oe_r <= scl_hold | (clock_pin_dir &
        (two_wire ? ~scl_level_r : 1'b1));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data pins chosen by wire mode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
      do_o_r <= `FSU_LATCH_RST;
      do_oe_r <= 1'b0;
    end
    else
    begin
      sda_o_r <= 1'b0;
      sda_oe_r <= two_wire & data_pin_dir & ~latch_r;
      do_o_r <= latch_r;
      do_oe_r <= ~two_wire & data_pin_dir;
    end
  end

  assign serial_clock_pin_o = scl_o_r;
  assign serial_clock_pin_oe = scl_oe_r;
  assign serial_data_in_pin_o = sda_o_r;
  assign serial_data_in_pin_oe = sda_oe_r;
  assign data_out_pin_o = do_o_r;
  assign data_out_pin_oe = do_oe_r;
  assign serial_shift_register = shift_r;
  assign counter_value = cnt_r;
  assign counter_overflow_flag = ovf_r;
  assign start_condition_flag = start_r;
  assign idle_wake = wake_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_write_wins: assert property (
    @(posedge sys_clk) disable iff (rst)
    data_wr |=> shift_r == $past(data_wdata))
    else $error("write lost to a shift");

  a_shift_in: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sample_ev && !data_wr) |=>
    shift_r == {$past(shift_r[6:0]), $past(di_sys)})
    else $error("shift did not take input bit");

  a_ovf_wrap: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cnt_ev && !counter_wr && cnt_r == 4'hF) |=>
    (cnt_r == 4'h0) && ovf_r)
    else $error("counter wrap without overflow");

  a_ovf_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ovf_set && overflow_flag_clear) |=> ovf_r ##1 wake_r)
    else $error("overflow lost in clear cycle");

  a_start_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    (start_set && !start_r) |=> start_r && hold_r == FSU_HOLD_ARMED)
    else $error("start not flagged");

  a_hold_low: assert property (
    @(posedge sys_clk) disable iff (rst)
    (hold_r == FSU_HOLD_LOW) |=>
    serial_clock_pin_oe && !serial_clock_pin_o)
    else $error("clock not held after start");

  a_clk_toggle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clock_toggle_strobe && !port_clock_toggle) |=>
    scl_level_r != $past(scl_level_r))
    else $error("toggle strobe ignored");

  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ext && sample_ev && !opp_ev) |=> $stable(latch_r))
    else $error("latch moved on sampling edge");

  a_both_edges: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ext && !software_clock_strobe && ev_fall && !counter_wr) |=>
    cnt_r == $past(cnt_r) + 4'h1)
    else $error("falling edge not counted");
endmodule

// >>> testbench/fsu_far_model.sv
`timescale 1ns/1ns

module fsu_far_model
(
  input wire logic link_clk,
  input wire logic clk_oe,
  input wire logic clk_o,
  input wire logic dat_oe,
  input wire logic do_pin,
  output logic scl_lvl,
  output logic sda_lvl
);
  logic m_clk = 1'b0;
  logic m_dat = 1'b0;
  // a driven pin wins over the far side, as on an open-drain line
  assign scl_lvl = clk_oe ? clk_o : m_clk;
  assign sda_lvl = dat_oe ? 1'b0 : m_dat;

  //////////////////////////////////////////////////////////////////////////
  // each level holds eight link cycles, well past the sync latency
  task automatic set_lines(input logic c, input logic d);
    @(posedge link_clk);
    m_clk <= c;
    m_dat <= d;
    repeat (8) @(posedge link_clk);
  endtask

  // clock only runs inside a frame; inv picks the idle level
  task automatic xfer(input logic [7:0] tx, input logic inv,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      set_lines(inv, tx[i]);
      set_lines(!inv, tx[i]);
      rx[i] = do_pin;
    end
    set_lines(inv, tx[0]);
  endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ns

module testbench;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] wire_mode = 2'h1;
  logic external_clock_select = 1'b0;
  logic external_edge_select = 1'b0;
  logic software_clock_strobe = 1'b0;
  logic clock_toggle_strobe = 1'b0;
  logic port_clock_toggle = 1'b0;
  logic clock_pin_dir = 1'b0;
  logic data_pin_dir = 1'b1;
  logic timer0_compare_match = 1'b0;
  logic data_wr = 1'b0;
  logic counter_wr = 1'b0;
  logic overflow_flag_clear = 1'b0;
  logic start_flag_clear = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [3:0] counter_wdata = 4'h0;
  logic scl_lvl, sda_lvl, serial_clock_pin_o, serial_clock_pin_oe;
  logic serial_data_in_pin_o, serial_data_in_pin_oe, data_out_pin_o;
  logic data_out_pin_oe, counter_overflow_flag, start_condition_flag;
  logic idle_wake;
  logic [7:0] serial_shift_register;
  logic [7:0] rx;
  logic [3:0] counter_value;
  int n_errors = 0;
  int checks_done = 0;

  always #5 sys_clk = ~sys_clk;
  always
  begin
    #8 link_clk = 1'b1;
    #7 link_clk = 1'b0;
  end

  fsu_top uut
  (
    .sys_clk, .rst, .link_clk, .serial_clock_pin_i(scl_lvl),
    .serial_clock_pin_o, .serial_clock_pin_oe,
    .serial_data_in_pin_i(sda_lvl), .serial_data_in_pin_o,
    .serial_data_in_pin_oe, .data_out_pin_o, .data_out_pin_oe,
    .wire_mode, .external_clock_select, .external_edge_select,
    .software_clock_strobe, .clock_toggle_strobe, .port_clock_toggle,
    .clock_pin_dir, .data_pin_dir, .timer0_compare_match, .data_wr,
    .data_wdata, .counter_wr, .counter_wdata, .overflow_flag_clear,
    .start_flag_clear, .serial_shift_register, .counter_value,
    .counter_overflow_flag, .start_condition_flag, .idle_wake
  );

  fsu_far_model far
  (
    .link_clk, .clk_oe(serial_clock_pin_oe), .clk_o(serial_clock_pin_o),
    .dat_oe(serial_data_in_pin_oe), .do_pin(data_out_pin_o),
    .scl_lvl, .sda_lvl
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_val(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    chk_val(what, {7'h00, exp}, {7'h00, got});
  endtask

  // data and counter written together; stale overflow flag cleared too
  task automatic load(input logic [7:0] d, input logic [3:0] c);
    @(posedge sys_clk);
    data_wr <= 1'b1;
    data_wdata <= d;
    counter_wr <= 1'b1;
    counter_wdata <= c;
    overflow_flag_clear <= 1'b1;
    @(posedge sys_clk);
    data_wr <= 1'b0;
    counter_wr <= 1'b0;
    overflow_flag_clear <= 1'b0;
  endtask

  // strobe held high n cycles: back to back shifts, the fastest rate
  task automatic strobes(input int n);
    @(posedge sys_clk);
    software_clock_strobe <= 1'b1;
    repeat (n) @(posedge sys_clk);
    software_clock_strobe <= 1'b0;
    wt(3);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_val("shift reg", 8'h00, serial_shift_register);
    chk_val("counter", 8'h00, {4'h0, counter_value});
    chk_bit("ovf flag", 1'b0, counter_overflow_flag);
    chk_bit("start flag", 1'b0, start_condition_flag);
  endtask

  // both toggles in one cycle cancel, so only the port toggle counts
  task automatic t_toggle;
    @(posedge sys_clk);
    clock_pin_dir <= 1'b1;
    clock_toggle_strobe <= 1'b1;
    @(posedge sys_clk);
    clock_toggle_strobe <= 1'b0;
    wt(3);
    chk_bit("clk pin", 1'b1, serial_clock_pin_o);
    chk_bit("clk oe", 1'b1, serial_clock_pin_oe);
    @(posedge sys_clk);
    port_clock_toggle <= 1'b1;
    clock_toggle_strobe <= 1'b1;
    @(posedge sys_clk);
    clock_toggle_strobe <= 1'b0;
    @(posedge sys_clk);
    port_clock_toggle <= 1'b0;
    clock_pin_dir <= 1'b0;
    wt(1);
    chk_bit("clk pin", 1'b0, serial_clock_pin_o);
  endtask

  task automatic t_strobe;
    far.set_lines(1'b0, 1'b0);
    load(8'hA5, 4'h0);
    strobes(4);
    chk_val("shift reg", 8'h50, serial_shift_register);
    chk_val("counter", 8'h04, {4'h0, counter_value});
    far.set_lines(1'b0, 1'b1);
    strobes(12);
    chk_val("shift reg", 8'hFF, serial_shift_register);
    chk_val("counter", 8'h00, {4'h0, counter_value});
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
    chk_bit("wake", 1'b1, idle_wake);
    chk_bit("data out", 1'b1, data_out_pin_o);
    chk_bit("data oe", 1'b1, data_out_pin_oe);
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b1;
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b0;
    wt(2);
    chk_bit("ovf flag", 1'b0, counter_overflow_flag);
  endtask

  task automatic t_collide;
    @(posedge sys_clk);
    data_wr <= 1'b1;
    data_wdata <= 8'h3C;
    software_clock_strobe <= 1'b1;
    @(posedge sys_clk);
    data_wr <= 1'b0;
    software_clock_strobe <= 1'b0;
    wt(3);
    chk_val("shift reg", 8'h3C, serial_shift_register);
  endtask

  task automatic t_ack;
    load(8'h00, 4'hE);
    strobes(2);
    chk_val("counter", 8'h00, {4'h0, counter_value});
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
    // overflow and its clear in one cycle: the set must win
    load(8'h00, 4'hF);
    @(posedge sys_clk);
    software_clock_strobe <= 1'b1;
    overflow_flag_clear <= 1'b1;
    @(posedge sys_clk);
    software_clock_strobe <= 1'b0;
    overflow_flag_clear <= 1'b0;
    wt(2);
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
    chk_val("counter", 8'h00, {4'h0, counter_value});
  endtask

  task automatic t_timer;
    @(posedge sys_clk);
    external_edge_select <= 1'b1;
    load(8'h00, 4'h0);
    timer0_compare_match <= 1'b1;
    repeat (3) @(posedge sys_clk);
    timer0_compare_match <= 1'b0;
    wt(3);
    chk_val("counter", 8'h03, {4'h0, counter_value});
  endtask

  // a full byte swapped with the far side in either clock mode
  task automatic t_ext(input logic inv);
    @(posedge sys_clk);
    external_clock_select <= 1'b1;
    external_edge_select <= inv;
    far.set_lines(inv, 1'b0);
    load(8'hC3, 4'h0);
    far.xfer(8'h96, inv, rx);
    wt(8);
    chk_val("shift reg", 8'h96, serial_shift_register);
    chk_val("far rx", 8'hC3, rx);
    chk_val("counter", 8'h00, {4'h0, counter_value});
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
  endtask

  task automatic t_start;
    @(posedge sys_clk);
    wire_mode <= 2'h2;
    external_edge_select <= 1'b0;
    data_pin_dir <= 1'b0;
    far.set_lines(1'b1, 1'b1);
    chk_bit("data oe", 1'b0, data_out_pin_oe);
    far.set_lines(1'b1, 1'b0);
    wt(2);
    chk_bit("start flag", 1'b1, start_condition_flag);
    far.set_lines(1'b0, 1'b0);
    wt(4);
    chk_bit("clk oe", 1'b1, serial_clock_pin_oe);
    chk_bit("clk pin", 1'b0, serial_clock_pin_o);
    far.set_lines(1'b1, 1'b0);
    chk_bit("scl", 1'b0, scl_lvl);
    chk_bit("start flag", 1'b1, start_condition_flag);
    @(posedge sys_clk);
    start_flag_clear <= 1'b1;
    @(posedge sys_clk);
    start_flag_clear <= 1'b0;
    wt(4);
    chk_bit("start flag", 1'b0, start_condition_flag);
    chk_bit("scl", 1'b1, scl_lvl);
  endtask

  // two-wire slave: overflow after an acknowledge preload holds the clock
  task automatic t_hold;
    @(posedge sys_clk);
    wire_mode <= 2'h3;
    data_pin_dir <= 1'b1;
    far.set_lines(1'b0, 1'b1);
    load(8'h00, 4'hE);
    wt(2);
    chk_bit("sda oe", 1'b1, serial_data_in_pin_oe);
    chk_bit("sda pin", 1'b0, serial_data_in_pin_o);
    chk_bit("sda", 1'b0, sda_lvl);
    far.set_lines(1'b1, 1'b1);
    far.set_lines(1'b0, 1'b1);
    far.set_lines(1'b1, 1'b1);
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
    chk_bit("clk oe", 1'b1, serial_clock_pin_oe);
    chk_bit("clk pin", 1'b0, serial_clock_pin_o);
    chk_bit("scl", 1'b0, scl_lvl);
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b1;
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b0;
    wt(4);
    chk_bit("clk oe", 1'b0, serial_clock_pin_oe);
    chk_bit("scl", 1'b1, scl_lvl);
  endtask

  // master: toggle strobes make the clock and also step the counter
  task automatic t_master;
    @(posedge sys_clk);
    wire_mode <= 2'h1;
    clock_pin_dir <= 1'b1;
    software_clock_strobe <= 1'b1;
    far.set_lines(1'b0, 1'b1);
    load(8'h5A, 4'h0);
    repeat (16)
    begin
      @(posedge sys_clk);
      clock_toggle_strobe <= 1'b1;
      @(posedge sys_clk);
      clock_toggle_strobe <= 1'b0;
      wt(12);
    end
    chk_val("shift reg", 8'hFF, serial_shift_register);
    chk_val("counter", 8'h00, {4'h0, counter_value});
    chk_bit("ovf flag", 1'b1, counter_overflow_flag);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wt(8);
    t_reset;
    t_toggle;
    t_strobe;
    t_collide;
    t_ack;
    t_timer;
    t_ext(1'b0);
    t_ext(1'b1);
    t_start;
    t_hold;
    t_master;
    end_sim;
  end

  // whole run needs about 10 us; a hang is cut off well after that
  initial
  begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
